// *** board_model.sv ***
// Board side: event pins and gate sources
`timescale 1ns/1ns
`default_nettype none
module board_model
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic gate_on_i,
   output logic ev0_o,
   output logic ev1_o,
   output logic irq0_n_o,
   output logic irq1_n_o,
   output logic keypad_o,
   output logic t2flag_o
);
   logic [5:0] left;
   // One event: 30 cycles low, then 30 high
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         left <= 6'h00;
      else if (go_i)
         left <= 6'h3c;
      else if (left != 6'h00)
         left <= left - 6'h01;
   end
   // Low phase spans several sample ticks
   assign ev0_o = !(left > 6'h1e);
   assign ev1_o = ev0_o;
   // Gate sources, all active or all idle
   assign irq0_n_o = !gate_on_i;
   assign irq1_n_o = !gate_on_i;
   assign keypad_o = gate_on_i;
   assign t2flag_o = gate_on_i;
endmodule
`default_nettype wire

// *** dual_timer_counter_pair.v ***
// Two 8/16-bit timer/counters with APB register access and clock outputs
//
// Functional notes
// R1: Timer function counts every twelfth clock
// R2: Fast select counts every system clock
// R3: Counter function counts event pin falls
// R4: Pin sampled per rate cycle, high-then-low
// R5: Count updates the cycle after detection
// R6: Mode 0 is 8-bit, flag on rollover
// R7: Two bits choose gate source
// R8: Mode 1 is 16-bit, same run/gate
// R9: Mode 2 reloads low from high byte
// R10: Timer 1 mode 3 holds timer 1
// R11: Split low byte uses timer 0 controls
// R12: Split high byte: timer, run1, flag1
// R13: Software sets timer 1 mode 3 first
// R14: Clock-out enable: reload mode, toggled pin
// R15: Clock-out reload gives half-rate square wave
// R16: Clock-out blocks interrupt, flag still set
// R17: Software programs clock-out before run bit
// R18: Timer 1 overflow serves baud and clock-out
// R19: Flag set on overflow, cleared on vector
// R20: Run bit stops or allows counting
// R21: Two-bit mode field per timer
// R22: Timer 0 three-bit clock source select
// R23: Timer 1 two-bit clock source select
// R24: Clock-out enable drives the clock pin
// R25: Count needs run and open gate
// R26: Count bytes read and written anytime
`timescale 1ns/1ns
`default_nettype none
`include "timer_pair_defines.vh"

module dual_timer_counter_pair
(
   input wire mclk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire tmr0_event_pin_i,
   input wire tmr1_event_pin_i,
   input wire ext_irq0_pin_n_i,
   input wire ext_irq1_pin_n_i,
   input wire keypad_irq_i,
   input wire tmr2_overflow_flag_i,
   input wire internal_low_osc_i,
   input wire watchdog_prescaler_tick_i,
   input wire tmr0_irq_ack_i,
   input wire tmr1_irq_ack_i,
   output reg tmr0_overflow_flag_o,
   output reg tmr1_overflow_flag_o,
   output reg tmr0_irq_req_o,
   output reg tmr1_irq_req_o,
   output reg tmr1_overflow_event_o,
   output reg tmr0_clkout_pin_o,
   output reg tmr1_clkout_pin_o
);

////////////////////////////////////////////////////////////////////////////////
// Register state

reg [7:0] timer_mode_select;
reg [7:0] tmr0_low_byte;
reg [7:0] tmr0_high_byte;
reg [7:0] tmr1_low_byte;
reg [7:0] tmr1_high_byte;
reg tmr0_run;
reg tmr1_run;
reg tmr0_fast_clk_sel;
reg tmr1_fast_clk_sel;
reg tmr0_clkout_en;
reg tmr1_clkout_en;
reg tmr0_prescale_ext;
reg tmr0_gate_sel_hi;
reg tmr1_gate_sel_hi;
reg [3:0] div12_cnt;
reg [1:0] div48_cnt;
reg [3:0] div192_cnt;

// Field views of the mode register
wire tmr0_gate_sel_lo = timer_mode_select[`MSEL_TMR0_GATE_LO];
wire tmr1_gate_sel_lo = timer_mode_select[`MSEL_TMR1_GATE_LO];
wire tmr0_count_sel = timer_mode_select[`MSEL_TMR0_COUNT];
wire tmr1_count_sel = timer_mode_select[`MSEL_TMR1_COUNT];
wire [1:0] tmr0_mode = timer_mode_select[`MSEL_TMR0_MODE_HI:`MSEL_TMR0_MODE_LO]; // R21
wire [1:0] tmr1_mode = timer_mode_select[`MSEL_TMR1_MODE_HI:`MSEL_TMR1_MODE_LO]; // R21

////////////////////////////////////////////////////////////////////////////////
// Shared prescaler: divide by 12, 48 and 192

wire tick12 = (div12_cnt == `DIV12_LAST);
wire tick48 = tick12 & (div48_cnt == `DIV48_LAST);
wire tick192 = tick12 & (div192_cnt == `DIV192_LAST);

// Free running chain of dividers
always @(posedge mclk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      div12_cnt <= 4'h0;
      div48_cnt <= 2'h0;
      div192_cnt <= 4'h0;
   end
   else
   begin
      div12_cnt <= tick12 ? 4'h0 : div12_cnt + 4'h1; // R1
      if (tick12)
      begin
         div48_cnt <= div48_cnt + 2'h1;
         div192_cnt <= div192_cnt + 4'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Event edge detection

wire tmr0_pin_event;
wire tmr1_pin_event;
wire low_osc_event;

// Event pins sampled at the machine-cycle rate
event_fall_sampler u_tmr0_pin
(
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .sample_i(tick12),
   .pin_i(tmr0_event_pin_i),
   .event_o(tmr0_pin_event)
);

event_fall_sampler u_tmr1_pin
(
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .sample_i(tick12),
   .pin_i(tmr1_event_pin_i),
   .event_o(tmr1_pin_event)
);

// Slow oscillator edges sampled every clock
event_fall_sampler u_low_osc
(
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .sample_i(1'b1),
   .pin_i(internal_low_osc_i),
   .event_o(low_osc_event)
);

////////////////////////////////////////////////////////////////////////////////
// Clock source and gate selection

reg tmr0_src;
reg tmr1_src;
reg tmr0_gate_open;
reg tmr1_gate_open;

// Timer 0 source {prescale ext, fast, count}
always @*
begin
   case ({tmr0_prescale_ext, tmr0_fast_clk_sel, tmr0_count_sel}) // R22
      3'b000: tmr0_src = tick12; // R1
      3'b001: tmr0_src = tmr0_pin_event; // R3 R5
      3'b010: tmr0_src = 1'b1; // R2
      3'b011: tmr0_src = low_osc_event;
      3'b100: tmr0_src = tick48;
      3'b101: tmr0_src = watchdog_prescaler_tick_i;
      3'b110: tmr0_src = tick192;
      default: tmr0_src = tmr1_overflow_event_o;
   endcase
end

// Timer 1 source {fast, count}
always @*
begin
   case ({tmr1_fast_clk_sel, tmr1_count_sel}) // R23
      2'b00: tmr1_src = tick12; // R1
      2'b01: tmr1_src = tmr1_pin_event; // R3 R5
      2'b10: tmr1_src = 1'b1; // R2
      default: tmr1_src = tick48;
   endcase
end

// Gate sources; the external interrupt pins are active low
always @*
begin
   case ({tmr0_gate_sel_hi, tmr0_gate_sel_lo}) // R7
      2'b00: tmr0_gate_open = 1'b1;
      2'b01: tmr0_gate_open = ~ext_irq0_pin_n_i;
      2'b10: tmr0_gate_open = tmr2_overflow_flag_i;
      default: tmr0_gate_open = keypad_irq_i;
   endcase
   case ({tmr1_gate_sel_hi, tmr1_gate_sel_lo}) // R7
      2'b00: tmr1_gate_open = 1'b1;
      2'b01: tmr1_gate_open = ~ext_irq1_pin_n_i;
      2'b10: tmr1_gate_open = tmr2_overflow_flag_i;
      default: tmr1_gate_open = keypad_irq_i;
   endcase
end

// Clock-out forces reload mode; split only without clock-out
wire [1:0] tmr0_eff_mode = tmr0_clkout_en ? `MODE_RELOAD8 : tmr0_mode; // R14
wire [1:0] tmr1_eff_mode = tmr1_clkout_en ? `MODE_RELOAD8 : tmr1_mode; // R14
wire tmr0_split = (tmr0_eff_mode == `MODE_SPLIT);
wire tmr1_held = (tmr1_mode == `MODE_SPLIT); // R10
wire tmr0_step = tmr0_src & tmr0_run & tmr0_gate_open; // R20 R25 R11
wire tmr1_step = tmr1_src & tmr1_run & tmr1_gate_open & ~tmr1_held; // R20 R25 R10
wire tmr0_high_src = tmr0_fast_clk_sel ? 1'b1 : tick12;
wire tmr0_high_step = tmr0_split & tmr1_run & tmr0_high_src; // R12

////////////////////////////////////////////////////////////////////////////////
// Counting

reg [7:0] cnt0_low;
reg [7:0] cnt0_high;
reg [7:0] cnt1_low;
reg [7:0] cnt1_high;
reg tmr0_ovf;
reg tmr1_ovf;
reg tmr0_high_ovf;

// Next count values per mode
always @*
begin
   cnt0_low = tmr0_low_byte;
   cnt0_high = tmr0_high_byte;
   cnt1_low = tmr1_low_byte;
   cnt1_high = tmr1_high_byte;
   tmr0_ovf = 1'b0;
   tmr1_ovf = 1'b0;
   tmr0_high_ovf = 1'b0;
   if (tmr0_step)
   begin
      tmr0_ovf = (tmr0_low_byte == 8'hff);
      cnt0_low = tmr0_low_byte + 8'h01; // R6 R11
      if (tmr0_eff_mode == `MODE_CNT16)
      begin
         tmr0_ovf = ({tmr0_high_byte, tmr0_low_byte} == 16'hffff); // R8
         if (tmr0_low_byte == 8'hff)
         begin
            cnt0_high = tmr0_high_byte + 8'h01; // R8
         end
      end
      else if ((tmr0_eff_mode == `MODE_RELOAD8) && tmr0_ovf)
      begin
         cnt0_low = tmr0_high_byte; // R9 R15
      end
   end
   if (tmr0_high_step)
   begin
      tmr0_high_ovf = (tmr0_high_byte == 8'hff);
      cnt0_high = tmr0_high_byte + 8'h01; // R12
   end
   if (tmr1_step)
   begin
      tmr1_ovf = (tmr1_low_byte == 8'hff);
      cnt1_low = tmr1_low_byte + 8'h01; // R6
      if (tmr1_eff_mode == `MODE_CNT16)
      begin
         tmr1_ovf = ({tmr1_high_byte, tmr1_low_byte} == 16'hffff); // R8
         if (tmr1_low_byte == 8'hff)
         begin
            cnt1_high = tmr1_high_byte + 8'h01; // R8
         end
      end
      else if ((tmr1_eff_mode == `MODE_RELOAD8) && tmr1_ovf)
      begin
         cnt1_low = tmr1_high_byte; // R9 R15
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// APB decode

wire [7:0] reg_idx = paddr_i[9:2];
wire addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00) &&
   ((reg_idx == `IDX_TIMER_CONTROL) || (reg_idx == `IDX_TIMER_MODE_SELECT) ||
   (reg_idx == `IDX_TMR0_LOW) || (reg_idx == `IDX_TMR1_LOW) ||
   (reg_idx == `IDX_TMR0_HIGH) || (reg_idx == `IDX_TMR1_HIGH) ||
   (reg_idx == `IDX_AUX_TIMER_CLOCK) || (reg_idx == `IDX_TIMER_EXT_SELECT));
wire wr_en = psel_i & penable_i & pready_o & pwrite_i & addr_ok;
wire wr_ctl = wr_en & (reg_idx == `IDX_TIMER_CONTROL);
wire [7:0] wbyte = pwdata_i[7:0];
reg [7:0] rd_byte;

// Read multiplexer; unused bits read as zero
always @*
begin
   if (reg_idx == `IDX_TIMER_CONTROL)
      rd_byte = {tmr1_overflow_flag_o, tmr1_run, tmr0_overflow_flag_o, tmr0_run, 4'h0};
   else if (reg_idx == `IDX_TIMER_MODE_SELECT)
      rd_byte = timer_mode_select;
   else if (reg_idx == `IDX_TMR0_LOW)
      rd_byte = tmr0_low_byte; // R26
   else if (reg_idx == `IDX_TMR1_LOW)
      rd_byte = tmr1_low_byte; // R26
   else if (reg_idx == `IDX_TMR0_HIGH)
      rd_byte = tmr0_high_byte; // R26
   else if (reg_idx == `IDX_TMR1_HIGH)
      rd_byte = tmr1_high_byte; // R26
   else if (reg_idx == `IDX_AUX_TIMER_CLOCK)
      rd_byte = {4'h0, tmr1_fast_clk_sel, tmr0_fast_clk_sel, tmr1_clkout_en, tmr0_clkout_en};
   else if (reg_idx == `IDX_TIMER_EXT_SELECT)
      rd_byte = {2'b00, tmr1_gate_sel_hi, tmr0_gate_sel_hi, 3'b000, tmr0_prescale_ext};
   else
      rd_byte = 8'h00;
end

// Zero-wait slave: answer in the access cycle
always @(posedge mclk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
   end
   else
   begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      if (psel_i & ~penable_i & ~pwrite_i)
      begin
         prdata_o <= {24'h000000, addr_ok ? rd_byte : 8'h00}; // Refused read gives zero
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Flags: hardware set beats software or vector clear

reg next_flag0;
reg next_flag1;

always @*
begin
   next_flag0 = tmr0_overflow_flag_o;
   next_flag1 = tmr1_overflow_flag_o;
   if (tmr0_irq_ack_i)
      next_flag0 = 1'b0; // R19
   if (tmr1_irq_ack_i)
      next_flag1 = 1'b0; // R19
   if (wr_ctl)
   begin
      next_flag0 = wbyte[`CTL_TMR0_FLAG]; // R19
      next_flag1 = wbyte[`CTL_TMR1_FLAG]; // R19
   end
   if (tmr0_ovf)
      next_flag0 = 1'b1; // R6 R9 R16
   if (tmr0_split ? tmr0_high_ovf : tmr1_ovf)
      next_flag1 = 1'b1; // R12 R19
end

////////////////////////////////////////////////////////////////////////////////
// Register update; a software write replaces the running count

always @(posedge mclk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      timer_mode_select <= `RST_BYTE;
      tmr0_low_byte <= `RST_BYTE;
      tmr0_high_byte <= `RST_BYTE;
      tmr1_low_byte <= `RST_BYTE;
      tmr1_high_byte <= `RST_BYTE;
      tmr0_run <= 1'b0;
      tmr1_run <= 1'b0;
      tmr0_fast_clk_sel <= 1'b0;
      tmr1_fast_clk_sel <= 1'b0;
      tmr0_clkout_en <= 1'b0;
      tmr1_clkout_en <= 1'b0;
      tmr0_prescale_ext <= 1'b0;
      tmr0_gate_sel_hi <= 1'b0;
      tmr1_gate_sel_hi <= 1'b0;
   end
   else
   begin
      tmr0_low_byte <= (wr_en && reg_idx == `IDX_TMR0_LOW) ? wbyte : cnt0_low; // R26
      tmr0_high_byte <= (wr_en && reg_idx == `IDX_TMR0_HIGH) ? wbyte : cnt0_high; // R26
      tmr1_low_byte <= (wr_en && reg_idx == `IDX_TMR1_LOW) ? wbyte : cnt1_low; // R26
      tmr1_high_byte <= (wr_en && reg_idx == `IDX_TMR1_HIGH) ? wbyte : cnt1_high; // R26
      if (wr_ctl)
      begin
         tmr0_run <= wbyte[`CTL_TMR0_RUN]; // R20
         tmr1_run <= wbyte[`CTL_TMR1_RUN]; // R20
      end
      if (wr_en && reg_idx == `IDX_TIMER_MODE_SELECT)
         timer_mode_select <= wbyte;
      if (wr_en && reg_idx == `IDX_AUX_TIMER_CLOCK)
      begin
         tmr1_fast_clk_sel <= wbyte[`AUX_TMR1_FAST];
         tmr0_fast_clk_sel <= wbyte[`AUX_TMR0_FAST];
         tmr1_clkout_en <= wbyte[`AUX_TMR1_CLKOUT];
         tmr0_clkout_en <= wbyte[`AUX_TMR0_CLKOUT];
      end
      if (wr_en && reg_idx == `IDX_TIMER_EXT_SELECT)
      begin
         tmr1_gate_sel_hi <= wbyte[`EXT_TMR1_GATE_HI];
         tmr0_gate_sel_hi <= wbyte[`EXT_TMR0_GATE_HI];
         tmr0_prescale_ext <= wbyte[`EXT_TMR0_PRESCALE];
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Flags, interrupt requests, overflow event and clock-out pins

always @(posedge mclk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      tmr0_overflow_flag_o <= 1'b0;
      tmr1_overflow_flag_o <= 1'b0;
      tmr0_irq_req_o <= 1'b0;
      tmr1_irq_req_o <= 1'b0;
      tmr1_overflow_event_o <= 1'b0;
      tmr0_clkout_pin_o <= 1'b0;
      tmr1_clkout_pin_o <= 1'b0;
   end
   else
   begin
      tmr0_overflow_flag_o <= next_flag0;
      tmr1_overflow_flag_o <= next_flag1;
      tmr0_irq_req_o <= next_flag0 & ~tmr0_clkout_en; // R16
      tmr1_irq_req_o <= next_flag1 & ~tmr1_clkout_en; // R16
      tmr1_overflow_event_o <= tmr1_ovf; // R18
      // Toggle per overflow gives 50% duty; low when disabled
      if (!tmr0_clkout_en)
         tmr0_clkout_pin_o <= 1'b0; // R24
      else if (tmr0_ovf)
         tmr0_clkout_pin_o <= ~tmr0_clkout_pin_o; // R14 R15
      if (!tmr1_clkout_en)
         tmr1_clkout_pin_o <= 1'b0; // R24
      else if (tmr1_ovf)
         tmr1_clkout_pin_o <= ~tmr1_clkout_pin_o; // R14 R15 R18
   end
end

endmodule

`default_nettype wire

// *** event_fall_sampler.v ***
// Samples a pin at a strobe and flags a high-to-low change one cycle later
`timescale 1ns/1ns
`default_nettype none

module event_fall_sampler
(
   input wire mclk_i,
   input wire rst_i,
   input wire sample_i,
   input wire pin_i,
   output reg event_o
);

reg last_sample;

// Previous sample kept; falling pair seen at a strobe gives a pulse
always @(posedge mclk_i or posedge rst_i)
begin
   if (rst_i)
   begin
      last_sample <= 1'b0;
      event_o <= 1'b0;
   end
   else
   begin
      if (sample_i)
      begin
         last_sample <= pin_i;
      end
      event_o <= sample_i & last_sample & ~pin_i; // R4
   end
end

endmodule

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the timer pair
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic go = 1'b0;
   logic gon = 1'b0;
   logic ack0 = 1'b0;
   logic ack1 = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, f0, f1, q0, q1, ovf_ev, ev0, ev1, i0n, i1n, kb, t2f;
   wire logic [1:0] ck;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int rs;
   int h;
   int n;
   logic [31:0] rdv;
   logic rerr;
   logic [7:0] q [$];
   logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha3, 8'h90};
   logic [71:0] tbl [19];

   dual_timer_counter_pair dual_timer_counter_pair_inst
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .tmr0_event_pin_i(ev0),
      .tmr1_event_pin_i(ev1), .ext_irq0_pin_n_i(i0n), .ext_irq1_pin_n_i(i1n),
      .keypad_irq_i(kb), .tmr2_overflow_flag_i(t2f), .internal_low_osc_i(ev0),
      .watchdog_prescaler_tick_i(go), .tmr0_irq_ack_i(ack0), .tmr1_irq_ack_i(ack1),
      .tmr0_overflow_flag_o(f0), .tmr1_overflow_flag_o(f1), .tmr0_irq_req_o(q0),
      .tmr1_irq_req_o(q1), .tmr1_overflow_event_o(ovf_ev), .tmr0_clkout_pin_o(ck[0]),
      .tmr1_clkout_pin_o(ck[1])
   );
   board_model board_model_inst
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .gate_on_i(gon), .ev0_o(ev0),
      .ev1_o(ev1), .irq0_n_o(i0n), .irq1_n_o(i1n), .keypad_o(kb), .t2flag_o(t2f)
   );

   // Clock and cycle count
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;

   task report_and_stop;
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus transfer; setup edge cycle kept in rs
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk_i);
      rs = cyc;
      penable <= 1'b1;
      do
      begin
         @(posedge mclk_i);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
      if (k >= 20)
      begin
         errors++;
         report_and_stop;
      end
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task rd(input logic [7:0] idx);
      xfer(1'b0, idx, 8'h00);
   endtask

   // Time between two changes of a clock pin, with overflow pulses
   task automatic period(input int w, input int exp);
      int c;
      int k;
      int p;
      logic v;
      k = 0;
      p = 0;
      v = ck[w];
      while (ck[w] === v && k < 600)
      begin
         @(posedge mclk_i);
         k++;
      end
      v = ck[w];
      c = cyc;
      while (ck[w] === v && k < 1200)
      begin
         @(posedge mclk_i);
         k++;
         p += ovf_ev;
      end
      chk(cyc - c, exp);
      if (w == 1)
         chk(p, 1);
      if (k >= 1200)
      begin
         errors++;
         report_and_stop;
      end
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(79788));
      // ctl, mode, aux, ext, gate, index, cycles, expected steps
      tbl = '{72'h10_01_00_00_00_8a_00f0_14, 72'h10_01_04_00_00_8a_0064_64,
         72'h10_01_00_01_00_8a_01e0_0a, 72'h10_01_04_01_00_8a_0300_04,
         72'h40_10_00_00_00_8b_00f0_14, 72'h40_10_08_00_00_8b_0064_64,
         72'h40_50_08_00_00_8b_01e0_0a, 72'h00_01_04_00_00_8a_0064_00,
         72'h10_09_04_00_00_8a_0064_00, 72'h10_09_04_00_01_8a_0064_64,
         72'h10_01_04_10_00_8a_0064_00, 72'h10_01_04_10_01_8a_0064_64,
         72'h10_09_04_10_01_8a_0064_64, 72'h40_90_08_00_00_8b_0064_00,
         72'h40_01_08_00_00_8b_012c_2c, 72'h40_31_08_00_00_8b_0064_00,
         72'h40_33_00_00_00_8c_00f0_14, 72'h10_33_04_00_00_8a_0064_64,
         72'h50_05_0c_01_00_8a_0200_02};
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      // Reset values, unmapped place, random count and mode values
      for (int i = 0; i < 8; i++)
      begin
         rd(regs[i]);
         chk(rdv, 0);
      end
      rd(8'h50);
      chk(rerr, 1);
      chk(rdv, 0);
      for (int i = 1; i < 6; i++)
      begin
         q.push_back(8'($urandom));
         wr(regs[i], q[$]);
      end
      for (int i = 1; i < 6; i++)
      begin
         rd(regs[i]);
         chk(rdv, q.pop_front());
      end
      // Count rate per source, mode, gate and run setting
      foreach (tbl[i])
      begin
         wr(8'h88, 8'h00);
         wr(8'h89, tbl[i][63:56]);
         wr(8'ha3, tbl[i][55:48]);
         wr(8'h90, tbl[i][47:40]);
         gon <= tbl[i][32];
         wr(8'h88, tbl[i][71:64]);
         rd(tbl[i][31:24]);
         h = rdv;
         n = rs;
         while (cyc < n + tbl[i][23:8] - 1) @(posedge mclk_i);
         rd(tbl[i][31:24]);
         chk((rdv - h) & 32'hff, tbl[i][7:0]);
      end
      // Both timers as clock generators from one reload value
      h = $urandom_range(8'hfc, 8'hf0);
      wr(8'h88, 8'h00);
      wr(8'h90, 8'h00);
      wr(8'h89, 8'h11);
      wr(8'ha3, 8'h0c);
      wr(8'h8c, h[7:0]);
      wr(8'h8d, h[7:0]);
      wr(8'h8a, h[7:0]);
      wr(8'h8b, h[7:0]);
      wr(8'ha3, 8'h0f);
      wr(8'h88, 8'h50);
      period(0, 256 - h);
      period(1, 256 - h);
      chk({f1, f0, q1, q0}, 4'hc);
      wr(8'ha3, 8'h00);
      @(posedge mclk_i);
      chk(ck, 2'b00);
      // Software set, then clear by vector acknowledge
      wr(8'h88, 8'ha0);
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      @(posedge mclk_i);
      chk({f1, f0}, 2'b11);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      @(posedge mclk_i);
      chk({f1, f0, q1, q0}, 4'h0);
      // Auto-reload from the high byte
      wr(8'h89, 8'h02);
      wr(8'ha3, 8'h04);
      wr(8'h8c, h[7:0]);
      wr(8'h8a, h[7:0]);
      wr(8'h88, 8'h10);
      n = 0;
      while (f0 !== 1'b1 && n < 300)
      begin
         @(posedge mclk_i);
         n++;
      end
      chk(q0, 1);
      if (n >= 300)
      begin
         errors++;
         report_and_stop;
      end
      wr(8'h88, 8'h00);
      rd(8'h8c);
      chk(rdv, h);
      rd(8'h8a);
      chk(rdv >= h, 1);
      // Event counting: pins, then watchdog tick and slow oscillator on timer 0
      wr(8'h89, 8'h55);
      for (int j = 0; j < 3; j++)
      begin
         wr(8'h90, {7'h00, j == 1});
         wr(8'ha3, {5'h00, j == 2, 2'b00});
         wr(8'h8a, 8'h00);
         wr(8'h8b, 8'h00);
         wr(8'h88, 8'h50);
         h = $urandom_range(6, 2);
         repeat (h)
         begin
            go <= 1'b1;
            @(posedge mclk_i);
            go <= 1'b0;
            repeat (70) @(posedge mclk_i);
         end
         rd(8'h8a);
         chk(rdv, h);
         rd(8'h8b);
         chk(rdv, h);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire

// *** timer_pair_chk.sv ***
// Port-level checker for the timer pair
`timescale 1ns/1ns
`default_nettype none
module timer_pair_chk
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic tmr0_overflow_flag_o,
   input wire logic tmr1_overflow_flag_o,
   input wire logic tmr0_irq_req_o,
   input wire logic tmr1_irq_req_o,
   input wire logic tmr0_clkout_pin_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // Bus answer and read data
   a_ready_follows: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_ready_single: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
      else $error("error outside access");
   a_err_rdata: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read not zero");
   a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("read upper bits set");
   // Interrupt requests and clock-out rises only with a set flag
   a_irq0_masked: assert property (tmr0_irq_req_o |-> tmr0_overflow_flag_o)
      else $error("irq0 without flag");
   a_irq1_masked: assert property (tmr1_irq_req_o |-> tmr1_overflow_flag_o)
      else $error("irq1 without flag");
   a_clk0_flag: assert property ($rose(tmr0_clkout_pin_o) |-> tmr0_overflow_flag_o)
      else $error("clock toggle without overflow");
   // Main scenarios
   cover property (pslverr_o);
   cover property ($rose(tmr0_clkout_pin_o));
   cover property (tmr1_irq_req_o);
endmodule
bind dual_timer_counter_pair timer_pair_chk timer_pair_chk_inst
(
   .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .tmr0_overflow_flag_o(tmr0_overflow_flag_o), .tmr1_overflow_flag_o(tmr1_overflow_flag_o),
   .tmr0_irq_req_o(tmr0_irq_req_o), .tmr1_irq_req_o(tmr1_irq_req_o),
   .tmr0_clkout_pin_o(tmr0_clkout_pin_o)
);
`default_nettype wire

// *** timer_pair_defines.vh ***
// Register indices, field positions and timing constants of the timer pair
`ifndef TIMER_PAIR_DEFINES_VH
`define TIMER_PAIR_DEFINES_VH

// Register indices; the byte address on the bus is four times the index
`define IDX_TIMER_CONTROL 8'h88
`define IDX_TIMER_MODE_SELECT 8'h89
`define IDX_TMR0_LOW 8'h8a
`define IDX_TMR1_LOW 8'h8b
`define IDX_TMR0_HIGH 8'h8c
`define IDX_TMR1_HIGH 8'h8d
`define IDX_AUX_TIMER_CLOCK 8'ha3
`define IDX_TIMER_EXT_SELECT 8'h90

// Reset values
`define RST_BYTE 8'h00

// Timer control fields
`define CTL_TMR1_FLAG 7
`define CTL_TMR1_RUN 6
`define CTL_TMR0_FLAG 5
`define CTL_TMR0_RUN 4

// Mode select fields
`define MSEL_TMR1_GATE_LO 7
`define MSEL_TMR1_COUNT 6
`define MSEL_TMR1_MODE_HI 5
`define MSEL_TMR1_MODE_LO 4
`define MSEL_TMR0_GATE_LO 3
`define MSEL_TMR0_COUNT 2
`define MSEL_TMR0_MODE_HI 1
`define MSEL_TMR0_MODE_LO 0

// Aux clock fields
`define AUX_TMR1_FAST 3
`define AUX_TMR0_FAST 2
`define AUX_TMR1_CLKOUT 1
`define AUX_TMR0_CLKOUT 0

// Extension select fields
`define EXT_TMR1_GATE_HI 5
`define EXT_TMR0_GATE_HI 4
`define EXT_TMR0_PRESCALE 0

// Operating modes
`define MODE_PWM8 2'b00
`define MODE_CNT16 2'b01
`define MODE_RELOAD8 2'b10
`define MODE_SPLIT 2'b11

// Prescaler terminal counts (divide by 12, then 4 and 16 more)
`define DIV12_LAST 4'hb
`define DIV48_LAST 2'h3
`define DIV192_LAST 4'hf

`endif
